// ---- rtl/timer8_counter_compare_unit.sv ----
// Purpose: 8-bit timer/counter, two compare channels, waveform outputs, AXI4-Lite registers
// Assumes: all inputs synchronous to aclk; crystal_pin_in is sampled, not a clock
// Notes: ce low freezes every flip-flop, including the bus slave
`timescale 1ns/10ps
`default_nettype none
module timer8_counter_compare_unit (
   // clock, reset, enable
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   // axi4-lite write address
   input wire logic awvalid,
   output logic awready,
   input wire logic [7:0] awaddr,
   // axi4-lite write data
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   // axi4-lite write response
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   // axi4-lite read address
   input wire logic arvalid,
   output logic arready,
   input wire logic [7:0] araddr,
   // axi4-lite read data
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   // crystal oscillator pins
   input wire logic crystal_pin_in,
   output logic crystal_pin_out,
   // port pins shared with the waveform outputs
   input wire logic [1:0] pin_direction_bit,
   input wire logic [1:0] port_data,
   output logic [1:0] wave_output,
   output logic [1:0] wave_output_oe,
   // interrupt requests and service acknowledges
   output logic irq_overflow,
   output logic irq_match_a,
   output logic irq_match_b,
   input wire logic ack_overflow,
   input wire logic ack_match_a,
   input wire logic ack_match_b
);
   import timer8_pkg::*;

   function automatic logic [3:0] reg_sel(input logic [7:0] addr);
      case (addr)
         OFF_CONTROL_REG_A: reg_sel = SEL_CONTROL_REG_A;
         OFF_CONTROL_REG_B: reg_sel = SEL_CONTROL_REG_B;
         OFF_COUNT_VALUE: reg_sel = SEL_COUNT_VALUE;
         OFF_COMPARE_REG_A: reg_sel = SEL_COMPARE_REG_A;
         OFF_COMPARE_REG_B: reg_sel = SEL_COMPARE_REG_B;
         OFF_FLAG_REG: reg_sel = SEL_FLAG_REG;
         OFF_MASK_REG: reg_sel = SEL_MASK_REG;
         OFF_ASYNC_STATUS_REG: reg_sel = SEL_ASYNC_STATUS_REG;
         OFF_LEVEL_REG: reg_sel = SEL_LEVEL_REG;
         default: reg_sel = SEL_NONE;
      endcase
   endfunction

   // prescaler tap: all ones in the low bits marks a divided tick
   function automatic logic [9:0] div_mask(input logic [2:0] cs);
      case (cs)
         3'h2: div_mask = 10'h007;
         3'h3: div_mask = 10'h01f;
         3'h4: div_mask = 10'h03f;
         3'h5: div_mask = 10'h07f;
         3'h6: div_mask = 10'h0ff;
         3'h7: div_mask = 10'h3ff;
         default: div_mask = 10'h000;
      endcase
   endfunction

   // next output state on a compare match
   function automatic logic match_action(input logic [1:0] com, input logic fast, input logic pc,
                                         input logic down, input logic cur, input logic may_toggle);
      if (com == COM_OFF) begin
         match_action = cur;
      end else if (!fast && !pc) begin
         case (com)
            COM_TOGGLE: match_action = ~cur;
            COM_CLEAR: match_action = 1'b0;
            default: match_action = 1'b1;
         endcase
      end else begin
         case (com)
            COM_TOGGLE: match_action = may_toggle ? ~cur : cur;
            COM_CLEAR: match_action = pc & down;
            default: match_action = ~(pc & down);
         endcase
      end
   endfunction

   // register state
   logic [7:0] control_reg_a;
   logic [3:0] control_reg_b;
   logic [7:0] count_value;
   logic [7:0] compare_reg [2];
   logic [7:0] compare_buf [2];
   logic [2:0] flags;
   logic [2:0] mask;
   logic async_clock_select;
   logic [1:0] oc_state;
   logic count_down;
   logic block_match;
   logic [9:0] prescale;
   logic crystal_q;

   // bus state
   logic aw_full;
   logic w_full;
   logic [7:0] aw_addr;
   logic [7:0] w_byte;
   logic w_strb0;

   logic [2:0] waveform_mode_field;
   logic [2:0] clock_select_field;
   logic [1:0] com [2];
   logic fast;
   logic pc;
   logic pwm;
   logic [7:0] top;
   logic src_pulse;
   logic timer_tick;
   logic at_top;
   logic at_bottom;
   logic at_max;
   logic wr_go;
   logic [3:0] wr_sel;
   logic cnt_wr;
   logic [1:0] force_req;
   logic [1:0] match;
   logic [2:0] flag_set;
   logic [2:0] flag_clr;
   logic [7:0] next_count;
   logic next_down;
   logic [7:0] rd_byte;
   logic rd_hit;

   assign waveform_mode_field = {control_reg_b[POS_WAVEFORM_MODE_BIT2],
                                 control_reg_a[POS_WAVEFORM_MODE_BIT1],
                                 control_reg_a[POS_WAVEFORM_MODE_BIT0]};
   assign clock_select_field = control_reg_b[POS_CLOCK_SELECT +: 3];
   assign com[0] = control_reg_a[POS_COM_A +: 2];
   assign com[1] = control_reg_a[POS_COM_B +: 2];
   assign fast = (waveform_mode_field == MODE_FAST_MAX) || (waveform_mode_field == MODE_FAST_OCRA);
   assign pc = (waveform_mode_field == MODE_PC_MAX) || (waveform_mode_field == MODE_PC_OCRA);
   assign pwm = fast || pc;
   assign top = (waveform_mode_field == MODE_CTC || waveform_mode_field == MODE_FAST_OCRA ||
                 waveform_mode_field == MODE_PC_OCRA) ? compare_reg[0] : COUNT_MAX;
   assign at_bottom = (count_value == COUNT_BOTTOM);
   assign at_max = (count_value == COUNT_MAX);
   assign at_top = (count_value == top);

   // tick source: io clock, or a sampled rising edge of the crystal input
   assign src_pulse = async_clock_select ? (crystal_pin_in & ~crystal_q) : 1'b1;
   assign timer_tick = src_pulse && (clock_select_field != CS_STOPPED) &&
                       ((prescale & div_mask(clock_select_field)) == div_mask(clock_select_field));

   assign wr_go = aw_full && w_full && !bvalid;
   assign wr_sel = reg_sel(aw_addr);
   assign cnt_wr = wr_go && w_strb0 && (wr_sel == SEL_COUNT_VALUE);
   assign force_req = (wr_go && w_strb0 && wr_sel == SEL_CONTROL_REG_B && !pwm) ?
                      {w_byte[POS_FORCE_B], w_byte[POS_FORCE_A]} : 2'b00;

   // counting sequence per mode
   always_comb begin
      next_count = count_value + 8'h01;
      next_down = count_down;
      if (pc) begin
         if (count_down) begin
            if (at_bottom) begin
               next_count = count_value + 8'h01;
               next_down = 1'b0;
            end else begin
               next_count = count_value - 8'h01;
            end
         end else if (at_top) begin
            next_count = count_value - 8'h01;
            next_down = 1'b1;
         end
      end else if ((fast || waveform_mode_field == MODE_CTC) && at_top) begin
         next_count = COUNT_BOTTOM;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         prescale <= RESET_PRESCALE;
         crystal_q <= 1'b0;
         crystal_pin_out <= 1'b0;
      end else if (ce) begin
         crystal_q <= crystal_pin_in;
         crystal_pin_out <= async_clock_select & ~crystal_pin_in;
         if (src_pulse && clock_select_field != CS_STOPPED) begin
            prescale <= prescale + 10'h001;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         count_value <= RESET_BYTE;
         count_down <= 1'b0;
      end else if (ce) begin
         if (cnt_wr) begin
            count_value <= w_byte;
         end else if (timer_tick) begin
            count_value <= next_count;
         end
         if (timer_tick) begin
            count_down <= next_down;
         end
      end
   end

   // a count write holds off matches until one tick has passed
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         block_match <= 1'b0;
      end else if (ce) begin
         if (cnt_wr) begin
            block_match <= 1'b1;
         end else if (timer_tick) begin
            block_match <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         control_reg_a <= RESET_BYTE;
         control_reg_b <= 4'h0;
         mask <= 3'h0;
         async_clock_select <= 1'b0;
      end else if (ce && wr_go && w_strb0) begin
         case (wr_sel)
            SEL_CONTROL_REG_A: control_reg_a <= w_byte;
            SEL_CONTROL_REG_B: control_reg_b <= w_byte[3:0];
            SEL_MASK_REG: mask <= w_byte[2:0];
            SEL_ASYNC_STATUS_REG: async_clock_select <= w_byte[POS_ASYNC_CLOCK_SELECT];
            default: ;
         endcase
      end
   end

   // overflow point depends on the mode
   assign flag_set[POS_OVERFLOW] = timer_tick && ((!pwm && at_max) || (fast && at_top) ||
                                   (pc && at_bottom && count_down));
   assign flag_set[POS_MATCH_A] = match[0];
   assign flag_set[POS_MATCH_B] = match[1];
   assign flag_clr = ((wr_go && w_strb0 && wr_sel == SEL_FLAG_REG) ? w_byte[2:0] : 3'h0) |
                     {ack_match_b, ack_match_a, ack_overflow};

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         flags <= 3'h0;
      end else if (ce) begin
         flags <= (flags & ~flag_clr) | flag_set;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_overflow <= 1'b0;
         irq_match_a <= 1'b0;
         irq_match_b <= 1'b0;
      end else if (ce) begin
         irq_overflow <= flags[POS_OVERFLOW] & mask[POS_OVERFLOW];
         irq_match_a <= flags[POS_MATCH_A] & mask[POS_MATCH_A];
         irq_match_b <= flags[POS_MATCH_B] & mask[POS_MATCH_B];
      end
   end

   genvar ch;
   generate
      for (ch = 0; ch < 2; ch++) begin : g_channel
         logic wr_cmp;
         assign wr_cmp = wr_go && w_strb0 && (wr_sel == (ch == 0 ? SEL_COMPARE_REG_A : SEL_COMPARE_REG_B));
         // equality seen at this tick raises the flag at the same edge as the next count
         assign match[ch] = timer_tick && !block_match && (count_value == compare_reg[ch]);

         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               compare_reg[ch] <= RESET_BYTE;
               compare_buf[ch] <= RESET_BYTE;
            end else if (ce) begin
               if (wr_cmp) begin
                  compare_buf[ch] <= w_byte;
               end
               if (!pwm && wr_cmp) begin
                  compare_reg[ch] <= w_byte;
               end else if (!pwm) begin
                  compare_reg[ch] <= compare_buf[ch];
               end else if (timer_tick && at_top && (fast || !count_down)) begin
                  compare_reg[ch] <= compare_buf[ch];
               end
            end
         end

         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               oc_state[ch] <= 1'b0;
            end else if (ce) begin
               if (force_req[ch]) begin
                  oc_state[ch] <= match_action(com[ch], 1'b0, 1'b0, 1'b0, oc_state[ch], 1'b0);
               end else if (match[ch]) begin
                  oc_state[ch] <= match_action(com[ch], fast, pc, count_down, oc_state[ch],
                                               ch == 0 && waveform_mode_field[2]);
               end else if (fast && timer_tick && at_top && com[ch] == COM_CLEAR) begin
                  oc_state[ch] <= 1'b1;
               end else if (fast && timer_tick && at_top && com[ch] == COM_SET) begin
                  oc_state[ch] <= 1'b0;
               end
            end
         end

         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               wave_output[ch] <= 1'b0;
               wave_output_oe[ch] <= 1'b0;
            end else if (ce) begin
               wave_output[ch] <= (com[ch] != COM_OFF) ? oc_state[ch] : port_data[ch];
               wave_output_oe[ch] <= pin_direction_bit[ch];
            end
         end
      end
   endgenerate

   // axi4-lite write channels
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready <= 1'b0;
         aw_full <= 1'b0;
         aw_addr <= RESET_BYTE;
      end else if (ce) begin
         if (awvalid && awready) begin
            aw_full <= 1'b1;
            awready <= 1'b0;
            aw_addr <= awaddr;
         end else if (bvalid && bready) begin
            aw_full <= 1'b0;
            awready <= 1'b1;
         end else if (!aw_full) begin
            awready <= 1'b1;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wready <= 1'b0;
         w_full <= 1'b0;
         w_byte <= RESET_BYTE;
         w_strb0 <= 1'b0;
      end else if (ce) begin
         if (wvalid && wready) begin
            w_full <= 1'b1;
            wready <= 1'b0;
            w_byte <= wdata[7:0];
            w_strb0 <= wstrb[0];
         end else if (bvalid && bready) begin
            w_full <= 1'b0;
            wready <= 1'b1;
         end else if (!w_full) begin
            wready <= 1'b1;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid <= 1'b0;
         bresp <= RESP_OKAY;
      end else if (ce) begin
         if (wr_go) begin
            bvalid <= 1'b1;
            bresp <= (wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
         end else if (bready) begin
            bvalid <= 1'b0;
         end
      end
   end

   // read mux
   always_comb begin
      rd_hit = 1'b1;
      rd_byte = RESET_BYTE;
      case (reg_sel(araddr))
         SEL_CONTROL_REG_A: rd_byte = control_reg_a;
         SEL_CONTROL_REG_B: rd_byte = {4'h0, control_reg_b};
         SEL_COUNT_VALUE: rd_byte = count_value;
         SEL_COMPARE_REG_A: rd_byte = compare_buf[0];
         SEL_COMPARE_REG_B: rd_byte = compare_buf[1];
         SEL_FLAG_REG: rd_byte = {5'h00, flags};
         SEL_MASK_REG: rd_byte = {5'h00, mask};
         SEL_ASYNC_STATUS_REG: rd_byte = {2'h0, async_clock_select, 5'h00};
         SEL_LEVEL_REG: rd_byte = {6'h00, at_max, at_bottom};
         default: rd_hit = 1'b0;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'b0;
         rvalid <= 1'b0;
         rdata <= 32'h0000_0000;
         rresp <= RESP_OKAY;
      end else if (ce) begin
         if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rdata <= {24'h00_0000, rd_byte};
            rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
         end else if (rvalid && rready) begin
            rvalid <= 1'b0;
            arready <= 1'b1;
         end else if (!rvalid) begin
            arready <= 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// ---- rtl/timer8_pkg.sv ----
// Purpose: shared constants of the 8-bit timer/counter with two compare channels
// Assumes: 32-bit AXI4-Lite register access, one aligned word per register
// Notes: registers hold up to 8 bits in the low byte, upper bits read as zero
package timer8_pkg;
   // register byte offsets
   localparam logic [7:0] OFF_CONTROL_REG_A = 8'h00;
   localparam logic [7:0] OFF_CONTROL_REG_B = 8'h04;
   localparam logic [7:0] OFF_COUNT_VALUE = 8'h08;
   localparam logic [7:0] OFF_COMPARE_REG_A = 8'h0c;
   localparam logic [7:0] OFF_COMPARE_REG_B = 8'h10;
   localparam logic [7:0] OFF_FLAG_REG = 8'h14;
   localparam logic [7:0] OFF_MASK_REG = 8'h18;
   localparam logic [7:0] OFF_ASYNC_STATUS_REG = 8'h1c;
   localparam logic [7:0] OFF_LEVEL_REG = 8'h20;
   // register indices returned by the address decoder
   localparam logic [3:0] SEL_CONTROL_REG_A = 4'h0;
   localparam logic [3:0] SEL_CONTROL_REG_B = 4'h1;
   localparam logic [3:0] SEL_COUNT_VALUE = 4'h2;
   localparam logic [3:0] SEL_COMPARE_REG_A = 4'h3;
   localparam logic [3:0] SEL_COMPARE_REG_B = 4'h4;
   localparam logic [3:0] SEL_FLAG_REG = 4'h5;
   localparam logic [3:0] SEL_MASK_REG = 4'h6;
   localparam logic [3:0] SEL_ASYNC_STATUS_REG = 4'h7;
   localparam logic [3:0] SEL_LEVEL_REG = 4'h8;
   localparam logic [3:0] SEL_NONE = 4'hf;
   // field positions
   localparam int POS_WAVEFORM_MODE_BIT0 = 0;
   localparam int POS_WAVEFORM_MODE_BIT1 = 1;
   localparam int POS_COM_B = 4;
   localparam int POS_COM_A = 6;
   localparam int POS_CLOCK_SELECT = 0;
   localparam int POS_WAVEFORM_MODE_BIT2 = 3;
   localparam int POS_FORCE_B = 6;
   localparam int POS_FORCE_A = 7;
   localparam int POS_OVERFLOW = 0;
   localparam int POS_MATCH_A = 1;
   localparam int POS_MATCH_B = 2;
   localparam int POS_ASYNC_CLOCK_SELECT = 5;
   localparam int POS_BOTTOM = 0;
   localparam int POS_MAX = 1;
   // counter landmarks
   localparam logic [7:0] COUNT_BOTTOM = 8'h00;
   localparam logic [7:0] COUNT_MAX = 8'hff;
   // waveform modes
   localparam logic [2:0] MODE_NORMAL = 3'h0;
   localparam logic [2:0] MODE_PC_MAX = 3'h1;
   localparam logic [2:0] MODE_CTC = 3'h2;
   localparam logic [2:0] MODE_FAST_MAX = 3'h3;
   localparam logic [2:0] MODE_PC_OCRA = 3'h5;
   localparam logic [2:0] MODE_FAST_OCRA = 3'h7;
   // compare output modes
   localparam logic [1:0] COM_OFF = 2'h0;
   localparam logic [1:0] COM_TOGGLE = 2'h1;
   localparam logic [1:0] COM_CLEAR = 2'h2;
   localparam logic [1:0] COM_SET = 2'h3;
   // clock select: zero stops the timer
   localparam logic [2:0] CS_STOPPED = 3'h0;
   // reset values
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [9:0] RESET_PRESCALE = 10'h000;
   // axi responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ---- verification/timer8_counter_compare_unit_sva.sv ----
// Purpose: port-level assertions for the 8-bit timer/counter
// Assumes: ce held high by the bench, one clock domain
// Notes: bound into every instance of the design
`timescale 1ns/10ps
`default_nettype none
module timer8_counter_compare_unit_sva (
   // clock, reset and enable
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   // register bus
   input wire logic awvalid,
   input wire logic awready,
   input wire logic [7:0] awaddr,
   input wire logic wvalid,
   input wire logic wready,
   input wire logic bvalid,
   input wire logic bready,
   input wire logic [1:0] bresp,
   input wire logic arvalid,
   input wire logic arready,
   input wire logic [7:0] araddr,
   input wire logic rvalid,
   input wire logic rready,
   input wire logic [31:0] rdata,
   // pins
   input wire logic [1:0] pin_direction_bit,
   input wire logic [1:0] wave_output_oe
);
   import timer8_pkg::*;
   logic [7:0] wr_addr;
   logic [7:0] rd_addr;
   // addresses of the transfers under way
   always_ff @(posedge aclk) begin
      if (awvalid && awready && ce) begin
         wr_addr <= awaddr;
      end
   end
   always_ff @(posedge aclk) begin
      if (arvalid && arready && ce) begin
         rd_addr <= araddr;
      end
   end
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn || !ce);
   a_oe_follows_dir: assert property ($past(aresetn) |-> wave_output_oe == $past(pin_direction_bit))
      else $error("oe mismatch");
   a_write_answer: assert property (awvalid && awready && wvalid && wready |=> ##1 bvalid)
      else $error("write answer late");
   a_read_answer: assert property (arvalid && arready |=> rvalid && rdata[31:8] == 24'h000000)
      else $error("read answer late");
   a_b_holds: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
      else $error("write response dropped");
   a_r_holds: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
      else $error("read data dropped");
   a_busy_refuses: assert property ((bvalid |-> !awready && !wready) and (rvalid |-> !arready))
      else $error("ready while busy");
   a_bad_addr_err: assert property (bvalid && wr_addr > 8'h20 |-> bresp == RESP_SLVERR)
      else $error("unmapped write not refused");
   a_good_addr_ok: assert property (bvalid && wr_addr < 8'h20 && wr_addr[1:0] == 2'b00 |-> bresp == RESP_OKAY)
      else $error("mapped write refused");
   a_level_exclusive: assert property (rvalid && rd_addr == OFF_LEVEL_REG |-> rdata[1:0] != 2'b11)
      else $error("bottom and max together");
   a_force_reads_zero: assert property (rvalid && rd_addr == OFF_CONTROL_REG_B |-> rdata[7:6] == 2'b00)
      else $error("force bits read back");
endmodule
bind timer8_counter_compare_unit timer8_counter_compare_unit_sva i_sva (.aclk, .aresetn, .ce, .awvalid, .awready,
   .awaddr, .wvalid, .wready, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata,
   .pin_direction_bit, .wave_output_oe);
`default_nettype wire

// ---- verification/timer8_counter_compare_unit_tb.sv ----
// Purpose: self-checking bench for the 8-bit timer/counter
// Assumes: ticks come from the crystal pin, toggled slowly by the bench
// Notes: a reference model tracks count, flags and output states
`timescale 1ns/10ps
`default_nettype none
module timer8_counter_compare_unit_tb;
   import timer8_pkg::*;
   logic aclk = 1'b0, aresetn = 1'b0, ce = 1'b1, crystal_pin_in = 1'b0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic ack_overflow = 1'b0, ack_match_a = 1'b0, ack_match_b = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h00000000;
   logic [3:0] wstrb = 4'h0;
   logic [1:0] pin_direction_bit = 2'h0, port_data = 2'h0;
   logic awready, wready, bvalid, arready, rvalid, crystal_pin_out, irq_overflow, irq_match_a, irq_match_b;
   logic [1:0] bresp, rresp, wave_output, wave_output_oe, b_resp, r_resp;
   logic [31:0] rdata, d;
   logic [7:0] m_cra = 8'h00, m_crb = 8'h00;
   int error_cnt = 0, checks_done = 0, cyc = 0;
   int m_cnt = 0, m_ca = 0, m_bufa = 0, m_cb = 0, m_fl = 0, m_msk = 0, m_blk = 0;
   int m_st[2] = '{0, 0};

   timer8_counter_compare_unit i_dut (.aclk, .aresetn, .ce, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata,
      .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp,
      .crystal_pin_in, .crystal_pin_out, .pin_direction_bit, .port_data, .wave_output, .wave_output_oe,
      .irq_overflow, .irq_match_a, .irq_match_b, .ack_overflow, .ack_match_a, .ack_match_b);

   always #5 aclk = ~aclk;

   task automatic end_sim();
      if (error_cnt == 0 && checks_done > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // output action of a match or force in the non-pwm modes
   task automatic act(input int c);
      logic [1:0] com;
      com = m_cra[7-2*c -: 2];
      if (com == COM_TOGGLE) m_st[c] = 1 - m_st[c];
      else if (com == COM_CLEAR) m_st[c] = 0;
      else if (com == COM_SET) m_st[c] = 1;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge aclk);
      awaddr <= a;
      wdata <= v;
      wstrb <= 4'hf;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid && !bready) bready <= 1'b1;
      end while (!(bvalid && bready));
      b_resp = bresp;
      bready <= 1'b0;
      case (a)
         OFF_CONTROL_REG_A: m_cra = v[7:0];
         OFF_CONTROL_REG_B: begin
            m_crb = v[7:0] & 8'h3f;
            for (int c = 0; c < 2; c++) if (v[7-c] && !m_cra[0]) act(c);
         end
         OFF_COUNT_VALUE: begin
            m_cnt = v[7:0];
            m_blk = 1;
         end
         OFF_COMPARE_REG_A: begin
            m_bufa = v[7:0];
            if (!m_cra[0]) m_ca = v[7:0];
         end
         OFF_COMPARE_REG_B: m_cb = v[7:0];
         OFF_FLAG_REG: m_fl = m_fl & ~int'(v[2:0]);
         OFF_MASK_REG: m_msk = v[2:0];
         default: ;
      endcase
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
         if (rvalid && !rready) rready <= 1'b1;
      end while (!(rvalid && rready));
      v = rdata;
      r_resp = rresp;
      rready <= 1'b0;
   endtask

   // one crystal period per tick; the model then advances by one tick
   task automatic tick(input int n);
      repeat (n) begin
         crystal_pin_in <= 1'b1;
         repeat (3) @(posedge aclk);
         crystal_pin_in <= 1'b0;
         repeat (3) @(posedge aclk);
         chk(crystal_pin_out, 1);
         if (m_blk == 0 && m_cnt == m_ca) begin
            m_fl |= 2;
            if (!m_cra[0]) act(0);
         end
         if (m_blk == 0 && m_cnt == m_cb) begin
            m_fl |= 4;
            if (!m_cra[0]) act(1);
         end
         m_blk = 0;
         if (m_cnt == 255) m_fl |= 1;
         if ({m_crb[3], m_cra[1:0]} == MODE_CTC && m_cnt == m_ca) m_cnt = 0;
         else m_cnt = (m_cnt + 1) % 256;
         if (m_cra[0] && m_cnt == 0) m_ca = m_bufa;
      end
   endtask

   task automatic ack(input logic [2:0] m);
      @(posedge aclk);
      {ack_match_b, ack_match_a, ack_overflow} <= m;
      @(posedge aclk);
      {ack_match_b, ack_match_a, ack_overflow} <= 3'b000;
      m_fl = m_fl & ~int'(m);
   endtask

   task automatic cmp_all();
      pin_direction_bit <= 2'($urandom);
      port_data <= 2'($urandom);
      rd(OFF_COUNT_VALUE, d);
      chk(d, m_cnt);
      rd(OFF_FLAG_REG, d);
      chk(d, m_fl);
      rd(OFF_COMPARE_REG_A, d);
      chk(d, m_bufa);
      chk({irq_match_b, irq_match_a, irq_overflow}, m_fl & m_msk);
      for (int c = 0; c < 2; c++) chk(wave_output[c], m_cra[7-2*c -: 2] != 0 ? m_st[c] : port_data[c]);
      chk(wave_output_oe, pin_direction_bit);
   endtask

   always @(posedge aclk) begin
      cyc++;
      if (cyc == 6000) begin
         error_cnt++;
         end_sim();
      end
   end

   initial begin
      int v;
      void'($urandom(32'hddcf));
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      for (int a = 0; a <= 32; a += 4) begin
         rd(8'(a), d);
         chk(d, a == 32 ? 1 : 0);
         chk(r_resp, RESP_OKAY);
      end
      // timer stopped: written values must stay put
      repeat (4) begin
         v = $urandom;
         wr(OFF_COUNT_VALUE, v);
         repeat (5) @(posedge aclk);
         rd(OFF_COUNT_VALUE, d);
         chk(d, m_cnt);
      end
      wr(OFF_COUNT_VALUE, 32'h000000ff);
      rd(OFF_LEVEL_REG, d);
      chk(d, 2);
      wr(8'h24, 32'h000000ff);
      chk(b_resp, RESP_SLVERR);
      wr(OFF_ASYNC_STATUS_REG, 32'h20);
      wr(OFF_MASK_REG, 7);
      wr(OFF_CONTROL_REG_B, 1);
      wr(OFF_COUNT_VALUE, 32'hfe);
      tick(2);
      cmp_all();
      ack(3'b001);
      cmp_all();
      wr(OFF_COMPARE_REG_A, 3);
      tick(3);
      cmp_all();
      tick(1);
      cmp_all();
      wr(OFF_FLAG_REG, 7);
      wr(OFF_COMPARE_REG_B, 32'h20);
      wr(OFF_COUNT_VALUE, 32'h20);
      tick(1);
      cmp_all();
      wr(OFF_CONTROL_REG_A, 32'h42);
      wr(OFF_COUNT_VALUE, 0);
      repeat (2) begin
         tick(4);
         cmp_all();
      end
      wr(OFF_CONTROL_REG_A, 32'h52);
      wr(OFF_CONTROL_REG_B, 32'h41);
      cmp_all();
      wr(OFF_CONTROL_REG_A, 32'h50);
      cmp_all();
      wr(OFF_CONTROL_REG_A, 0);
      tick(4);
      wr(OFF_CONTROL_REG_A, 32'h50);
      cmp_all();
      // fast pwm: a new compare value waits for the wrap
      wr(OFF_CONTROL_REG_A, 3);
      wr(OFF_FLAG_REG, 7);
      wr(OFF_COUNT_VALUE, 32'h10);
      wr(OFF_COMPARE_REG_A, 32'h12);
      tick(3);
      cmp_all();
      wr(OFF_COUNT_VALUE, 32'hfe);
      tick(22);
      cmp_all();
      end_sim();
   end
endmodule
`default_nettype wire
